// >>> verilog/cbm_defs.svh
// Purpose: Register map, field positions and codes of the comparator blanking mask.
// Assumes: One 32-bit APB word per register; 16 bits of data sit in the low half.
// Notes: Definitions only.
`ifndef CBM_DEFS_SVH
`define CBM_DEFS_SVH

`define CBM_ADDR_W 12
`define CBM_SRC_OFS 12'h000
`define CBM_GATE_OFS 12'h004

`define CBM_SRC_RST 16'h0000
`define CBM_GATE_RST 16'h0000
`define CBM_SRC_WMASK 16'h0fff
`define CBM_GATE_WMASK 16'hbfff

`define CBM_SRC_C_LSB 8
`define CBM_SRC_B_LSB 4
`define CBM_SRC_A_LSB 0
`define CBM_SRC_UNUSED_LSB 12

`define CBM_LVL_BIT 15
`define CBM_RSVD_BIT 14
`define CBM_OR_C_T_BIT 13
`define CBM_OR_C_N_BIT 12
`define CBM_OR_B_T_BIT 11
`define CBM_OR_B_N_BIT 10
`define CBM_OR_A_T_BIT 9
`define CBM_OR_A_N_BIT 8
`define CBM_AND_N_OR_BIT 7
`define CBM_AND_T_OR_BIT 6
`define CBM_AND_C_T_BIT 5
`define CBM_AND_C_N_BIT 4
`define CBM_AND_B_T_BIT 3
`define CBM_AND_B_N_BIT 2
`define CBM_AND_A_T_BIT 1
`define CBM_AND_A_N_BIT 0

`define CBM_CODE_PWM_GEN1_LOW_OUT 4'h0
`define CBM_CODE_PWM_GEN6_HIGH_OUT 4'hb
`define CBM_CODE_TRIG18 4'hc
`define CBM_CODE_TRIG19 4'hd
`define CBM_CODE_FAULT_INPUT_2 4'he
`define CBM_CODE_FAULT_INPUT_4 4'hf

`endif

// >>> verilog/cbm_pkg.sv
// Purpose: Types shared by the comparator blanking mask.
// Assumes: Six PWM generators with a low and a high output each.
// Notes: Constants live in cbm_defs.svh.
package cbm_pkg;

   typedef struct packed {
      logic fault_input_4;
      logic fault_input_2;
      logic trigger_gen_out_19;
      logic trigger_gen_out_18;
      logic [5:0] pwm_high;
      logic [5:0] pwm_low;
   } cbm_src_t;

   typedef struct packed {
      logic [3:0] mask_c_source;
      logic [3:0] mask_b_source;
      logic [3:0] mask_a_source;
   } cbm_sel_t;

endpackage : cbm_pkg

// >>> verilog/cbm_blanking.sv
// Purpose: Blanking mask of one comparator channel with its two APB registers.
// Assumes: CMP_IN is the polarity-adjusted comparator output, synchronous to CLK_IN.
// Notes: Instantiate once per channel; the blanked output lags its inputs by one clock.
`timescale 1ns/1ps
`include "cbm_defs.svh"

// Operation
// - Three 4-bit source fields C, B, A
// - Codes 0-11 pick PWM low/high outputs
// - Codes 12-15 pick triggers and faults
// - Unused bits ignore writes, read zero
// - Bit 15 picks the blanked level
// - Bit 13 feeds true C to OR
// - Bit 12 feeds inverted C to OR
// - Bit 11 feeds true B to OR
// - Bit 10 feeds inverted B to OR
// - Bit 9 feeds true A to OR
// - Bit 8 feeds inverted A to OR
// - Bit 7 feeds inverted AND to OR
// - Bit 6 feeds true AND to OR
// - Bit 5 feeds true C to AND
// - Bits 3, 2 feed B to AND
// - Bits 1, 0 feed A to AND
module cbm_blanking (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [`CBM_ADDR_W-1:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [3:0] PSTRB_IN,
   output logic PREADY_OUT,
   output logic [31:0] PRDATA_OUT,
   output logic PSLVERR_OUT,
   input wire cbm_pkg::cbm_src_t SRC_IN,
   input wire logic CMP_IN,
   output logic BLANK_ACTIVE_OUT,
   output logic CMP_BLANKED_OUT
);

   // Maps a 4-bit source code onto the sixteen candidate signals
   function automatic logic pick_source(input logic [3:0] code,
                                        input cbm_pkg::cbm_src_t s);
      logic [15:0] v;
      v = 16'h0000;
      for (int k = 0; k < 6; k++) begin
         v[2*k] = s.pwm_low[k];
         v[2*k+1] = s.pwm_high[k];
      end
      v[`CBM_CODE_TRIG18] = s.trigger_gen_out_18;
      v[`CBM_CODE_TRIG19] = s.trigger_gen_out_19;
      v[`CBM_CODE_FAULT_INPUT_2] = s.fault_input_2;
      v[`CBM_CODE_FAULT_INPUT_4] = s.fault_input_4;
      return v[code];
   endfunction : pick_source

   // Merges byte lanes of a write into a 16-bit register, keeping unused bits at zero
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] wdata,
                                           input logic [3:0] strb,
                                           input logic [15:0] wmask);
      logic [15:0] m;
      m = old;
      if (strb[0]) begin
         m[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         m[15:8] = wdata[15:8];
      end
      return m & wmask;
   endfunction : merge16

   logic [15:0] src_r;
   logic [15:0] src_nxt;
   logic [15:0] gate_r;
   logic [15:0] gate_nxt;
   logic pready_r;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic pslverr_r;
   logic blank_r;
   logic cmp_out_r;

   // APB decode
   wire logic setup_phase = PSEL_IN && !PENABLE_IN && !pready_r;
   wire logic access_done = PSEL_IN && PENABLE_IN && pready_r;
   wire logic hit_src = (PADDR_IN == `CBM_SRC_OFS);
   wire logic hit_gate = (PADDR_IN == `CBM_GATE_OFS);
   wire logic hit_any = hit_src || hit_gate;
   wire logic wr_src = access_done && PWRITE_IN && hit_src;
   wire logic wr_gate = access_done && PWRITE_IN && hit_gate;

   // Unused bit positions are masked off at write time, so reads show zero
   assign src_nxt = wr_src ?
      merge16(src_r, PWDATA_IN, PSTRB_IN, `CBM_SRC_WMASK) : src_r;
   assign gate_nxt = wr_gate ?
      merge16(gate_r, PWDATA_IN, PSTRB_IN, `CBM_GATE_WMASK) : gate_r;
   assign prdata_nxt = hit_src ? {16'h0000, src_r} :
                       hit_gate ? {16'h0000, gate_r} : 32'h0000_0000;

   // Registers
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         src_r <= `CBM_SRC_RST;
         gate_r <= `CBM_GATE_RST;
      end else begin
         src_r <= src_nxt;
         gate_r <= gate_nxt;
      end
   end

   // Answer prepared in the setup cycle, so every access has no wait state
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup_phase;
         prdata_r <= (setup_phase && !PWRITE_IN) ? prdata_nxt : 32'h0000_0000;
         pslverr_r <= setup_phase && !hit_any;
      end
   end

   // Field views
   cbm_pkg::cbm_sel_t sel;
   assign sel.mask_c_source = src_r[`CBM_SRC_C_LSB +: 4];
   assign sel.mask_b_source = src_r[`CBM_SRC_B_LSB +: 4];
   assign sel.mask_a_source = src_r[`CBM_SRC_A_LSB +: 4];

   wire logic masking_level_select = gate_r[`CBM_LVL_BIT];
   wire logic mask_c_signal = pick_source(sel.mask_c_source, SRC_IN);
   wire logic mask_b_signal = pick_source(sel.mask_b_source, SRC_IN);
   wire logic mask_a_signal = pick_source(sel.mask_a_source, SRC_IN);

   // AND gate; each input that is not enabled drops out as a logic one
   wire logic and_c_t = !gate_r[`CBM_AND_C_T_BIT] || mask_c_signal;
   wire logic and_c_n = !gate_r[`CBM_AND_C_N_BIT] || !mask_c_signal;
   wire logic and_b_t = !gate_r[`CBM_AND_B_T_BIT] || mask_b_signal;
   wire logic and_b_n = !gate_r[`CBM_AND_B_N_BIT] || !mask_b_signal;
   wire logic and_a_t = !gate_r[`CBM_AND_A_T_BIT] || mask_a_signal;
   wire logic and_a_n = !gate_r[`CBM_AND_A_N_BIT] || !mask_a_signal;
   // An AND gate with no input enabled reads low, so an empty gate blanks only through bit 7 (inverted AND to OR)
   wire logic and_any = |gate_r[`CBM_AND_C_T_BIT:`CBM_AND_A_N_BIT];
   wire logic mask_and_output = and_any && and_c_t && and_c_n && and_b_t
                                && and_b_n && and_a_t && and_a_n;

   // OR gate; disabled inputs drop out as a logic zero
   wire logic or_c_t = gate_r[`CBM_OR_C_T_BIT] && mask_c_signal;
   wire logic or_c_n = gate_r[`CBM_OR_C_N_BIT] && !mask_c_signal;
   wire logic or_b_t = gate_r[`CBM_OR_B_T_BIT] && mask_b_signal;
   wire logic or_b_n = gate_r[`CBM_OR_B_N_BIT] && !mask_b_signal;
   wire logic or_a_t = gate_r[`CBM_OR_A_T_BIT] && mask_a_signal;
   wire logic or_a_n = gate_r[`CBM_OR_A_N_BIT] && !mask_a_signal;
   wire logic or_and_n = gate_r[`CBM_AND_N_OR_BIT] && !mask_and_output;
   wire logic or_and_t = gate_r[`CBM_AND_T_OR_BIT] && mask_and_output;
   wire logic blank_nxt = or_c_t || or_c_n || or_b_t || or_b_n || or_a_t
                          || or_a_n || or_and_n || or_and_t;

   // Level select 1 holds the output high (hides low assertions), 0 holds it low
   wire logic cmp_nxt = blank_nxt ? masking_level_select : CMP_IN;

   // Registered so that the outputs are glitch free despite the gate network
   always_ff @(posedge CLK_IN) begin
      if (!RESETN_IN) begin
         blank_r <= 1'b0;
         cmp_out_r <= 1'b0;
      end else begin
         blank_r <= blank_nxt;
         cmp_out_r <= cmp_nxt;
      end
   end

   assign PREADY_OUT = pready_r;
   assign PRDATA_OUT = prdata_r;
   assign PSLVERR_OUT = pslverr_r;
   assign BLANK_ACTIVE_OUT = blank_r;
   assign CMP_BLANKED_OUT = cmp_out_r;

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   sequence s_setup_write(logic [`CBM_ADDR_W-1:0] ofs);
      PSEL_IN && !PENABLE_IN && PWRITE_IN && PADDR_IN == ofs && PSTRB_IN == 4'hf;
   endsequence

   sequence s_access_held;
      PSEL_IN && PENABLE_IN && PWRITE_IN && $stable(PADDR_IN) && $stable(PWDATA_IN);
   endsequence

   sequence s_setup_read(logic [`CBM_ADDR_W-1:0] ofs);
      PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == ofs;
   endsequence

   a_src_write_map: assert property (
      s_setup_write(`CBM_SRC_OFS) ##1 s_access_held |=>
         src_r == ($past(PWDATA_IN[15:0]) & `CBM_SRC_WMASK))
      else $error("Source select write not stored with upper bits cleared");

   a_gate_write_map: assert property (
      s_setup_write(`CBM_GATE_OFS) ##1 s_access_held |=>
         gate_r == ($past(PWDATA_IN[15:0]) & `CBM_GATE_WMASK))
      else $error("Gating control write not stored with bit 14 cleared");

   a_read_upper_zero: assert property (
      PREADY_OUT && !PWRITE_IN |-> PRDATA_OUT[31:16] == 16'h0000)
      else $error("Unused read bits not zero");

   a_reset_clear: assert property (@(posedge CLK_IN) disable iff (1'b0)
      !RESETN_IN |=> src_r == `CBM_SRC_RST && gate_r == `CBM_GATE_RST
                     && !BLANK_ACTIVE_OUT)
      else $error("Registers not cleared by reset");

   a_code_pwm_first: assert property (
      sel.mask_a_source == `CBM_CODE_PWM_GEN1_LOW_OUT && gate_r[`CBM_OR_A_T_BIT]
      && SRC_IN.pwm_low[0] |=> BLANK_ACTIVE_OUT)
      else $error("Code 0 did not select the first PWM low output");

   a_code_pwm_last: assert property (
      sel.mask_b_source == `CBM_CODE_PWM_GEN6_HIGH_OUT && gate_r == 16'h0800
      |=> BLANK_ACTIVE_OUT == $past(SRC_IN.pwm_high[5]))
      else $error("Code 11 did not select the last PWM high output");

   a_code_fault: assert property (
      sel.mask_c_source == `CBM_CODE_FAULT_INPUT_4 && gate_r == 16'h2000
      |=> BLANK_ACTIVE_OUT == $past(SRC_IN.fault_input_4))
      else $error("Code 15 did not select fault input 4");

   a_or_inverted_c: assert property (
      gate_r == 16'h1000 |=> BLANK_ACTIVE_OUT == !$past(mask_c_signal))
      else $error("Inverted mask C not reaching the OR gate alone");

   a_and_true_path: assert property (
      gate_r == 16'h0042 |=> BLANK_ACTIVE_OUT == $past(mask_a_signal))
      else $error("AND gate with mask A not routed to the OR gate");

   a_and_invert_path: assert property (
      gate_r == 16'h0088 |=> BLANK_ACTIVE_OUT == $past(mask_b_signal == 1'b0))
      else $error("Inverted AND output not routed to the OR gate");

   a_blank_level: assert property (
      BLANK_ACTIVE_OUT |-> CMP_BLANKED_OUT == $past(gate_r[`CBM_LVL_BIT]))
      else $error("Blanked comparator not held at the selected level");

   a_pass_through: assert property (
      !blank_nxt ##1 1'b1 |-> CMP_BLANKED_OUT == $past(CMP_IN))
      else $error("Unblanked comparator output not passed through");

   a_empty_gates: assert property (
      gate_r[`CBM_RSVD_BIT-1:0] == 14'h0000 |=> !BLANK_ACTIVE_OUT)
      else $error("Blanking active with every gate input disconnected");

   a_read_src_upper: assert property (
      s_setup_read(`CBM_SRC_OFS) |=> PREADY_OUT && PRDATA_OUT[15:12] == 4'h0)
      else $error("Source select read shows unused upper bits");

   a_read_gate_rsvd: assert property (
      s_setup_read(`CBM_GATE_OFS) |=> PREADY_OUT && !PRDATA_OUT[`CBM_RSVD_BIT])
      else $error("Gating control read shows the reserved bit");

   a_code_trigger: assert property (
      sel.mask_a_source == `CBM_CODE_TRIG18 && gate_r == 16'h0200
      |=> BLANK_ACTIVE_OUT == $past(SRC_IN.trigger_gen_out_18))
      else $error("Code 12 did not select trigger output 18");

   a_or_true_c: assert property (
      gate_r == 16'h2000 |=> BLANK_ACTIVE_OUT == $past(mask_c_signal))
      else $error("True mask C not reaching the OR gate alone");

   a_or_true_b: assert property (
      gate_r == 16'h0800 |=> BLANK_ACTIVE_OUT == $past(mask_b_signal))
      else $error("True mask B not reaching the OR gate alone");

   a_or_inverted_b: assert property (
      gate_r == 16'h0400 |=> BLANK_ACTIVE_OUT == !$past(mask_b_signal))
      else $error("Inverted mask B not reaching the OR gate alone");

   a_or_true_a: assert property (
      gate_r == 16'h0200 |=> BLANK_ACTIVE_OUT == $past(mask_a_signal))
      else $error("True mask A not reaching the OR gate alone");

   a_or_inverted_a: assert property (
      gate_r == 16'h0100 |=> BLANK_ACTIVE_OUT == !$past(mask_a_signal))
      else $error("Inverted mask A not reaching the OR gate alone");

   a_and_c_true: assert property (
      gate_r == 16'h0060 |=> BLANK_ACTIVE_OUT == $past(mask_c_signal))
      else $error("True mask C not reaching the AND gate");

   a_and_c_inverted: assert property (
      gate_r == 16'h0050 |=> BLANK_ACTIVE_OUT == !$past(mask_c_signal))
      else $error("Inverted mask C not reaching the AND gate");

   a_and_b_inverted: assert property (
      gate_r == 16'h0044 |=> BLANK_ACTIVE_OUT == !$past(mask_b_signal))
      else $error("Inverted mask B not reaching the AND gate");

   a_and_a_inverted: assert property (
      gate_r == 16'h0041 |=> BLANK_ACTIVE_OUT == !$past(mask_a_signal))
      else $error("Inverted mask A not reaching the AND gate");

endmodule : cbm_blanking

// >>> testbench/cbm_src_model.sv
// Purpose: Stand-in for the PWM generators, trigger generator and fault inputs.
// Assumes: The bench chooses the 16 source levels as one pattern.
// Notes: Levels are registered, as real generator outputs would be.
`timescale 1ns/1ps
module cbm_src_model (
   input wire logic clk_in,
   input wire logic [15:0] pat_in,
   output cbm_pkg::cbm_src_t src_out
);
   // Registered so source edges never land in the sampling step of the mask
   always_ff @(posedge clk_in) begin
      src_out <= cbm_pkg::cbm_src_t'(pat_in);
   end
endmodule : cbm_src_model

// >>> testbench/testbench.sv
// Purpose: Self-checking bench of the comparator blanking mask.
// Assumes: Zero wait-state APB, outputs one clock after their inputs.
// Notes: Strobes stay all-on; partial lane writes are not exercised.
`timescale 1ns/1ps
`include "cbm_defs.svh"
module testbench;
   logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, cmp = 0, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, rdata, prdata;
   logic [15:0] pat = '0;
   logic blank, cmpo, pready, pslverr;
   cbm_pkg::cbm_src_t src;
   int err_count = 0, cmp_count = 0;
   cbm_src_model model (.clk_in(clk), .pat_in(pat), .src_out(src));
   cbm_blanking dut (.CLK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hf),
      .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .SRC_IN(src),
      .CMP_IN(cmp), .BLANK_ACTIVE_OUT(blank), .CMP_BLANKED_OUT(cmpo));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // Wait states are the slave's business; only the watchdog ends a hung wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      chk("apb_ready", 1, pready);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      // Idle cycle keeps two drives of psel out of one time step
      @(posedge clk);
   endtask : apb
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
      input logic e_err);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdata);
      chk({nm, "_err"}, e_err, err);
   endtask : rd
   task automatic run(input logic [15:0] g, input logic [15:0] p, input logic c,
      input logic eb);
      apb(1'b1, `CBM_GATE_OFS, 32'(g));
      pat <= p;
      cmp <= c;
      // One clock in the source model, one in the mask, one before the check sees the registered outputs
      repeat (3) @(posedge clk);
      chk("blank", eb, blank);
      chk("cmp_out", eb ? g[15] : c, cmpo);
   endtask : run
   task automatic t_reset;
      rd("src_rst", `CBM_SRC_OFS, 32'h0, 1'b0);
      rd("gate_rst", `CBM_GATE_OFS, 32'h0, 1'b0);
      chk("blank_rst", 0, blank);
   endtask : t_reset
   task automatic t_reserved;
      apb(1'b1, `CBM_SRC_OFS, 32'hffffffff);
      rd("src_bits", `CBM_SRC_OFS, 32'h0fff, 1'b0);
      apb(1'b1, `CBM_GATE_OFS, 32'hffffffff);
      rd("gate_bits", `CBM_GATE_OFS, 32'hbfff, 1'b0);
      apb(1'b1, 12'h008, 32'h1234);
      chk("wr_unmapped_err", 1, err);
      rd("unmapped", 12'h008, 32'h0, 1'b1);
      rd("src_keep", `CBM_SRC_OFS, 32'h0fff, 1'b0);
   endtask : t_reserved
   task automatic t_sources;
      int idx;
      logic [15:0] gt, gn, hit;
      for (int f = 0; f < 3; f++) begin
         for (int code = 0; code < 16; code++) begin
            apb(1'b1, `CBM_SRC_OFS, 32'(code << (4 * f)));
            idx = code < 12 ? (code % 2) * 6 + code / 2 : code;
            gt = 16'(1 << (9 + 2 * f));
            gn = 16'(1 << (8 + 2 * f));
            hit = 16'(1 << idx);
            run(gt, hit, 1'b1, 1'b1);
            run(gt, ~hit, 1'b1, 1'b0);
            run(gn, ~hit, 1'b1, 1'b1);
            run(gn, hit, 1'b0, 1'b0);
         end
      end
   endtask : t_sources
   task automatic t_and;
      int idx;
      logic [15:0] g, p;
      logic e;
      // Sources: A on pwm_low[0], B on pwm_high[0], C on pwm_low[1]
      apb(1'b1, `CBM_SRC_OFS, 32'h0210);
      for (int j = 0; j < 6; j++) begin
         idx = j < 2 ? 0 : (j < 4 ? 6 : 1);
         for (int k = 6; k < 8; k++) begin
            for (int s = 0; s < 2; s++) begin
               g = 16'((1 << k) | (1 << j));
               p = 16'(s << idx);
               e = 1'(s ^ (j % 2 == 0) ^ (k == 7));
               run(g, p, 1'b1, e);
            end
         end
      end
      run(16'h004a, 16'h0041, 1'b1, 1'b1);
      run(16'h004a, 16'h0001, 1'b1, 1'b0);
      run(16'h0080, 16'h0000, 1'b1, 1'b1);
   endtask : t_and
   task automatic t_level;
      run(16'h8200, 16'h0001, 1'b0, 1'b1);
      run(16'h0200, 16'h0001, 1'b1, 1'b1);
      run(16'h8200, 16'h0000, 1'b0, 1'b0);
   endtask : t_level
   // Reset in mid-run must clear registers that hold real values
   task automatic t_mid_reset;
      apb(1'b1, `CBM_SRC_OFS, 32'h0000_0abc);
      apb(1'b1, `CBM_GATE_OFS, 32'h0000_8200);
      pat <= 16'hffff;
      repeat (3) @(posedge clk);
      chk("blank_pre_rst", 1, blank);
      chk("cmp_pre_rst", 1, cmpo);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      chk("blank_mid_rst", 0, blank);
      chk("cmp_mid_rst", 0, cmpo);
      rd("src_mid_rst", `CBM_SRC_OFS, 32'h0, 1'b0);
      rd("gate_mid_rst", `CBM_GATE_OFS, 32'h0, 1'b0);
   endtask : t_mid_reset
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_reset();
      t_reserved();
      t_sources();
      t_and();
      t_level();
      t_mid_reset();
      stop_test();
   end
   // The full run needs about 1500 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      stop_test();
   end
endmodule : testbench
